//--- logic/ssc_pkg.sv
// ssc_pkg: register map, field positions and helpers for the serial clock and buffer block
// assumes a 32-bit apb slave, one aligned word per register, byte address = index * 4
package ssc_pkg;
    // register indices and byte addresses
    localparam logic [7:0]  RX_BUF_IDX   = 8'h2b;
    localparam logic [7:0]  TX_BUF_IDX   = RX_BUF_IDX;
    localparam logic [7:0]  CTRL_IDX     = 8'h31;
    localparam logic [7:0]  STAT_IDX     = 8'h32;
    localparam logic [11:0] RX_BUF_ADDR  = {2'b00, RX_BUF_IDX, 2'b00};
    localparam logic [11:0] TX_BUF_ADDR  = {2'b00, TX_BUF_IDX, 2'b00};
    localparam logic [11:0] CTRL_ADDR    = {2'b00, CTRL_IDX, 2'b00};
    localparam logic [11:0] STAT_ADDR    = {2'b00, STAT_IDX, 2'b00};
    // control field positions
    localparam int          CTRL_START_BIT = 7;
    localparam int          CTRL_INH_BIT   = 6;
    localparam int          CTRL_MODE_LSB  = 4;
    localparam int          CTRL_DIR_BIT   = 3;
    localparam int          CTRL_SEL_LSB   = 0;
    // reset values
    localparam logic [7:0]  RX_RESET     = 8'h00;
    localparam logic [7:0]  IDLE_DATA    = 8'hff;
    localparam logic [2:0]  SEL_RESET    = 3'h0;
    // clock select codes and timing
    localparam logic [2:0]  SEL_FS       = 3'h0;
    localparam logic [2:0]  SEL_EXT      = 3'h7;
    localparam logic [2:0]  FS_HALF_LAST = 3'h7;   // fs/16: half period of 8 fs ticks
    localparam int          DIV_MIN_W    = 12;

    typedef enum logic [1:0] {MODE_TX, MODE_RX, MODE_TXRX, MODE_RSVD} ssc_mode_t;
    typedef enum logic [1:0] {ST_IDLE, ST_BYTE, ST_WAIT} ssc_state_t;

    // mode uses the transmit buffer
    function automatic logic has_tx(input ssc_mode_t m);
        return (m == MODE_TX) || (m == MODE_TXRX);
    endfunction
    // mode uses the receive buffer
    function automatic logic has_rx(input ssc_mode_t m);
        return (m == MODE_RX) || (m == MODE_TXRX);
    endfunction
    // bit that goes out first for the chosen order
    function automatic logic first_bit(input logic [7:0] d, input logic msb);
        return msb ? d[7] : d[0];
    endfunction
    // shift one received bit in at the far end
    function automatic logic [7:0] shift_in(input logic [7:0] d, input logic b, input logic msb);
        return msb ? {d[6:0], b} : {b, d[7:1]};
    endfunction
endpackage

//--- logic/ssc_shift_if.sv
// ssc_shift_if: edge events and data between the control logic and the shift engine
// assumes both ends run on the same system clock
`timescale 1ns/1ps
interface ssc_shift_if;
    logic       fall;
    logic       rise;
    logic       abort;
    logic       msb_first;
    logic       sdi;
    logic [7:0] load_data;
    logic [7:0] data;
    logic       sdo;
    logic       busy;
    logic       done;
    modport ctrl (output fall, rise, abort, msb_first, sdi, load_data,
                  input  data, sdo, busy, done);
    modport eng  (input  fall, rise, abort, msb_first, sdi, load_data,
                  output data, sdo, busy, done);
endinterface

//--- logic/ssc_clkgen.sv
// ssc_clkgen: half-period ticks of the internal serial clock
// assumes fc is clk and fs arrives as a one-cycle fs_tick pulse
`timescale 1ns/1ps
module ssc_clkgen import ssc_pkg::*; #(
    parameter int DIV_W = 12
) (
    input  wire logic       clk,
    input  wire logic       reset_n,
    input  wire logic [2:0] clock_sel,
    input  wire logic       divider_option_bit,
    input  wire logic       slow_mode,
    input  wire logic       fs_tick,
    output logic            half_tick
);
    logic [DIV_W-1:0] div_cnt;
    logic [2:0]       fs_cnt;
    logic [DIV_W-1:0] mask;
    logic             next_half_tick;

    generate
        if (DIV_W < DIV_MIN_W) begin : g_chk
            $error("ssc_clkgen: DIV_W too small for fc/4096");
        end
    endgenerate

    // free running fc divider
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            div_cnt <= '0;
        end else begin
            div_cnt <= div_cnt + 1'b1;
        end
    end

    // fs divider
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            fs_cnt <= 3'h0;
        end else if (fs_tick) begin
            fs_cnt <= fs_cnt + 3'h1;
        end
    end

    always_comb begin
        mask = '0;
        case (clock_sel)
            3'h0:    mask = DIV_W'(12'h7ff);
            3'h1:    mask = DIV_W'(12'h07f);
            3'h2:    mask = DIV_W'(12'h03f);
            3'h3:    mask = DIV_W'(12'h01f);
            3'h4:    mask = DIV_W'(12'h00f);
            3'h5:    mask = DIV_W'(12'h007);
            3'h6:    mask = DIV_W'(12'h003);
            default: mask = '0;
        endcase
        if (clock_sel == SEL_FS && (slow_mode || divider_option_bit)) begin
            next_half_tick = fs_tick && (fs_cnt == FS_HALF_LAST);
        end else if (slow_mode) begin
            next_half_tick = 1'b0;   // reserved codes in slow modes
        end else begin
            next_half_tick = (div_cnt & mask) == mask;
        end
    end

    // free running ticks release a wait within half a period
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            half_tick <= 1'b0;
        end else begin
            half_tick <= next_half_tick;
        end
    end
endmodule // ssc_clkgen

//--- logic/ssc_shifter.sv
// ssc_shifter: one shared shift register, out on the leading edge, in on the trailing edge
// assumes fall and rise are single-cycle events that alternate
`timescale 1ns/1ps
module ssc_shifter import ssc_pkg::*; (
    input  wire logic clk,
    input  wire logic reset_n,
    ssc_shift_if.eng  sh
);
    logic [2:0] bit_cnt;

    // shift register, bit counter and end-of-byte pulse
    always_ff @(posedge clk) begin
        if (!reset_n || sh.abort) begin
            sh.data <= IDLE_DATA;
            sh.sdo  <= 1'b1;
            sh.busy <= 1'b0;
            sh.done <= 1'b0;
            bit_cnt <= 3'h0;
        end else begin
            sh.done <= 1'b0;
            if (sh.fall) begin
                // drive next bit on falling pin edge
                if (!sh.busy) begin
                    sh.data <= sh.load_data;
                    sh.sdo  <= first_bit(sh.load_data, sh.msb_first);
                    sh.busy <= 1'b1;
                end else begin
                    sh.sdo  <= first_bit(sh.data, sh.msb_first);
                end
            end else if (sh.rise && sh.busy) begin
                sh.data <= shift_in(sh.data, sh.sdi, sh.msb_first);
                bit_cnt <= bit_cnt + 3'h1;
                if (bit_cnt == 3'h7) begin
                    sh.busy <= 1'b0;
                    sh.done <= 1'b1;
                end
            end
        end
    end
endmodule // ssc_shifter

//--- logic/ssc_top.sv
// ssc_top: synchronous 8-bit serial port, buffers, clock source, auto wait, bit order
// assumes an apb master on clk and a serial partner on clock and data pins
//
// Behaviour
// - receive buffer reads zero after reset
// - transmit buffer shares address, write only
// - writes dropped while transmit buffer full
// - internal codes drive clock pin out
// - internal clock pin high outside transfers
// - internal clock stops until buffers serviced
// - clock resumes within one serial period
// - codes select fc or fs divisions
// - code 111 uses external pin clock
// - transmit shifts on falling pin edge
// - receive samples on rising pin edge
// - one bit order for both directions
// - order zero sends bit7 first
// - order one sends bit0 first
// - busy flag high during transfer
// - empty flag tracks pending transmit data
//
// Chosen here: the APB slave port.
`timescale 1ns/1ps
module ssc_top import ssc_pkg::*; (
    input  wire logic        clk,
    input  wire logic        reset_n,
    input  wire logic [11:0] paddr,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] pwdata,
    input  wire logic [3:0]  pstrb,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic        divider_option_bit,
    input  wire logic        slow_mode,
    input  wire logic        fs_tick,
    input  wire logic        serial_clock_pin_in,
    output logic             serial_clock_pin_out,
    output logic             serial_clock_pin_oe_n,
    input  wire logic        serial_data_in,
    output logic             serial_data_out
);
    ////////////////////////////////////////////////////////////////////////////////
    // declarations
    logic       start;
    ssc_mode_t  mode;
    logic       bit_order_select;
    logic [2:0] clock_sel;
    logic [7:0] rx_buffer;
    logic [7:0] tx_buffer;
    logic       tx_empty;
    logic       rx_full;
    ssc_state_t state;
    logic       sclk_out;
    logic       sck_meta;
    logic       sck_sync;
    logic       sck_prev;
    logic       half_tick;
    logic       acc;
    logic       wr_en;
    logic       wr_tx;
    logic       wr_ctrl;
    logic       rd_rx;
    logic       inhibit;
    logic [31:0] rd_val;
    logic       rd_err;
    logic       ext_mode;
    logic       ext_fall;
    logic       ext_rise;
    logic       ready;
    logic       can_begin;
    logic       fall_ev;
    logic       rise_ev;
    logic       msb_first;
    logic       in_progress;
    logic [7:0] ctrl_byte;
    logic [7:0] stat_byte;

    ssc_shift_if sh ();

    ////////////////////////////////////////////////////////////////////////////////
    // apb decode, zero wait states
    assign acc     = psel && penable;
    assign wr_en   = acc && pwrite && pstrb[0];
    assign wr_tx   = wr_en && (paddr == TX_BUF_ADDR);
    assign wr_ctrl = wr_en && (paddr == CTRL_ADDR);
    assign rd_rx   = acc && !pwrite && (paddr == RX_BUF_ADDR);
    assign inhibit = wr_ctrl && pwdata[CTRL_INH_BIT];
    assign pready  = 1'b1;
    assign pslverr = acc && rd_err;

    // register images
    assign in_progress = (state != ST_IDLE);
    assign ctrl_byte   = {start, 1'b0, mode, bit_order_select, clock_sel};
    assign stat_byte   = {in_progress, sh.busy, tx_empty, rx_full, 4'h0};

    // read mux and unmapped detection
    always_comb begin
        rd_val = 32'h0;
        rd_err = 1'b0;
        if (paddr == RX_BUF_ADDR) begin
            // reads at the shared address return receive data
            rd_val = {24'h0, rx_buffer};
        end else if (paddr == CTRL_ADDR) begin
            rd_val = {24'h0, ctrl_byte};
        end else if (paddr == STAT_ADDR) begin
            rd_val = {24'h0, stat_byte};
        end else begin
            rd_err = 1'b1;
        end
    end

    // read data captured in the setup phase
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            prdata <= 32'h0;
        end else if (psel && !penable && !pwrite) begin
            prdata <= rd_val;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // control register; inhibit clears start and self-clears
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            start            <= 1'b0;
            mode             <= MODE_TX;
            bit_order_select <= 1'b0;
            clock_sel        <= SEL_RESET;
        end else if (wr_ctrl) begin
            start            <= pwdata[CTRL_START_BIT] && !pwdata[CTRL_INH_BIT];
            mode             <= ssc_mode_t'(pwdata[CTRL_MODE_LSB +: 2]);
            bit_order_select <= pwdata[CTRL_DIR_BIT];
            clock_sel        <= pwdata[CTRL_SEL_LSB +: 3];
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // transmit buffer and its empty flag
    always_ff @(posedge clk) begin
        if (!reset_n || inhibit) begin
            tx_buffer <= IDLE_DATA;
            tx_empty  <= 1'b1;
        end else begin
            if (wr_tx && tx_empty) begin
                tx_buffer <= pwdata[7:0];
                tx_empty  <= 1'b0;
            end
            // empty again once moved to the shifter, set wins
            if (fall_ev && !sh.busy && has_tx(mode)) begin
                tx_empty <= 1'b1;
            end
        end
    end

    // receive buffer and its full flag
    always_ff @(posedge clk) begin
        if (!reset_n || inhibit) begin
            rx_buffer <= RX_RESET;
            rx_full   <= 1'b0;
        end else begin
            if (rd_rx) begin
                rx_full <= 1'b0;
            end
            // overrun keeps the unread byte; a byte landing as the old one is read
            // is stored, so the set wins over the read clear
            if (sh.done && has_rx(mode) && (!rx_full || rd_rx)) begin
                rx_buffer <= sh.data;
                rx_full   <= 1'b1;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // two-stage synchroniser then edge detect
    always_ff @(posedge clk) begin
        if (!reset_n) begin
            sck_meta <= 1'b1;
            sck_sync <= 1'b1;
            sck_prev <= 1'b1;
        end else begin
            sck_meta <= serial_clock_pin_in;
            sck_sync <= sck_meta;
            sck_prev <= sck_sync;
        end
    end
    assign ext_fall = sck_prev && !sck_sync;
    assign ext_rise = !sck_prev && sck_sync;

    ssc_clkgen #(
        .DIV_W (12)
    ) u_clkgen (
        .clk                (clk),
        .reset_n            (reset_n),
        .clock_sel          (clock_sel),
        .divider_option_bit (divider_option_bit),
        .slow_mode          (slow_mode),
        .fs_tick            (fs_tick),
        .half_tick          (half_tick)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // edge events for the shift engine
    assign ext_mode  = (clock_sel == SEL_EXT);
    // internal clock waits for buffer service
    assign ready     = (!has_tx(mode) || !tx_empty) && (!has_rx(mode) || !rx_full);
    assign can_begin = start && (state != ST_BYTE) && (ext_mode || ready);
    always_comb begin
        if (ext_mode) begin
            // external pin edges clock the shifter
            fall_ev = ext_fall && (sh.busy || can_begin);
            rise_ev = ext_rise && sh.busy;
        end else begin
            fall_ev = half_tick && sclk_out && (sh.busy || can_begin);
            rise_ev = half_tick && !sclk_out;
        end
    end

    // one order setting feeds both directions
    assign msb_first    = !bit_order_select;
    assign sh.msb_first = msb_first;
    assign sh.fall      = fall_ev;
    assign sh.rise      = rise_ev;
    assign sh.abort     = inhibit;
    assign sh.sdi       = serial_data_in;
    assign sh.load_data = has_tx(mode) ? tx_buffer : IDLE_DATA;

    ssc_shifter u_shifter (
        .clk     (clk),
        .reset_n (reset_n),
        .sh      (sh)
    );

    assign serial_data_out = sh.sdo;

    ////////////////////////////////////////////////////////////////////////////////
    // transfer state behind the busy flag
    always_ff @(posedge clk) begin
        if (!reset_n || inhibit) begin
            state <= ST_IDLE;
        end else begin
            case (state)
                ST_IDLE: begin
                    if (fall_ev && can_begin) begin
                        state <= ST_BYTE;
                    end
                end
                ST_BYTE: begin
                    if (sh.done) begin
                        state <= start ? ST_WAIT : ST_IDLE;
                    end
                end
                ST_WAIT: begin
                    if (!start) begin
                        state <= ST_IDLE;
                    end else if (fall_ev) begin
                        state <= ST_BYTE;
                    end
                end
                default: begin
                    state <= ST_IDLE;
                end
            endcase
        end
    end

    // internal clock idles high and toggles on ticks
    always_ff @(posedge clk) begin
        if (!reset_n || inhibit || ext_mode) begin
            sclk_out <= 1'b1;
        end else if (fall_ev) begin
            sclk_out <= 1'b0;
        end else if (rise_ev) begin
            sclk_out <= 1'b1;
        end
    end

    // drive the pin for internal codes only
    assign serial_clock_pin_out  = sclk_out;
    assign serial_clock_pin_oe_n = ext_mode;

    ////////////////////////////////////////////////////////////////////////////////
    // checks
    // full buffer ignores writes
    tx_write_drop_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_tx && !tx_empty && !inhibit) |=> $stable(tx_buffer))
        else $error("transmit buffer changed while full");
    tx_accept_a: assert property (@(posedge clk) disable iff (!reset_n)
        (wr_tx && tx_empty && !inhibit && !(fall_ev && !sh.busy && has_tx(mode)))
        |=> (!tx_empty && tx_buffer == $past(pwdata[7:0])))
        else $error("accepted write not held in transmit buffer");
    rx_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        (psel && !penable && !pwrite && paddr == RX_BUF_ADDR)
        |=> (prdata == {24'h0, $past(rx_buffer)}))
        else $error("read at buffer address not receive data");
    idle_high_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!ext_mode && state == ST_IDLE) |-> serial_clock_pin_out)
        else $error("internal clock low while idle");
    ext_release_a: assert property (@(posedge clk) disable iff (!reset_n)
        (clock_sel == SEL_EXT) |-> serial_clock_pin_oe_n)
        else $error("clock pin driven in external mode");
    wait_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!ext_mode && state == ST_WAIT && !ready && sclk_out && !wr_ctrl)
        |=> serial_clock_pin_out)
        else $error("clock ran during automatic wait");
    msb_first_a: assert property (@(posedge clk) disable iff (!reset_n)
        (fall_ev && !sh.busy && msb_first && !inhibit)
        |=> (serial_data_out == $past(sh.load_data[7])))
        else $error("first bit is not bit7");
    lsb_first_a: assert property (@(posedge clk) disable iff (!reset_n)
        (fall_ev && !sh.busy && !msb_first && !inhibit)
        |=> (serial_data_out == $past(sh.load_data[0])))
        else $error("first bit is not bit0");
    // busy flag rises with first edge
    busy_flag_a: assert property (@(posedge clk) disable iff (!reset_n)
        (state == ST_IDLE && fall_ev && can_begin && !inhibit) |=> stat_byte[7] ##1 1'b1)
        else $error("transfer flag not set at first edge");
    // data out changes only after a falling edge
    shift_edge_a: assert property (@(posedge clk) disable iff (!reset_n)
        (!fall_ev && !inhibit) |=> $stable(serial_data_out))
        else $error("data out changed without falling edge");
    sample_rise_a: assert property (@(posedge clk) disable iff (!reset_n)
        (rise_ev && sh.busy && msb_first && !inhibit) |=> (sh.data[0] == $past(serial_data_in)))
        else $error("receive bit not sampled on rising edge");
endmodule // ssc_top

//--- testbench/ssc_partner.sv
// ssc_partner: serial device on the far side of the pins
// assumes sck is the resolved pin level and clk is the system clock
`timescale 1ns/1ps
module ssc_partner (
    input  wire logic       clk,
    input  wire logic       sck,
    input  wire logic       sdo,
    input  wire logic       msb_first,
    input  wire logic [7:0] tx_byte,
    output logic            ext_sck,
    output logic            sdi,
    output logic [7:0]      rx_byte,
    output int              nbits
);
    // the pin leaves unknown at reset, which looks like a rising edge;
    // only a rise that follows a fall counts as a bit
    logic armed;
    initial begin
        armed = 1'b0;
        ext_sck = 1'b1;
        sdi = 1'b1;
        rx_byte = 8'h00;
        nbits = 0;
    end
    // next bit after each falling edge
    always @(negedge sck) begin
        sdi <= msb_first ? tx_byte[7 - nbits % 8] : tx_byte[nbits % 8];
        armed <= 1'b1;
    end
    // sample on rising edge, scramble line once the byte is over
    always @(posedge sck) begin
        if (armed) begin
            armed <= 1'b0;
            rx_byte <= msb_first ? {rx_byte[6:0], sdo} : {sdo, rx_byte[7:1]};
            nbits <= nbits + 1;
            if (nbits % 8 == 7) begin
                fork
                    begin
                        repeat (5) @(posedge clk);
                        sdi <= ~sdi;
                    end
                join_none
            end
        end
    end
    // one external frame, phases six clk long
    task automatic ext_frame();
        repeat (8) begin
            ext_sck <= 1'b0;
            repeat (6) @(posedge clk);
            ext_sck <= 1'b1;
            repeat (6) @(posedge clk);
        end
    endtask
endmodule // ssc_partner

//--- testbench/sync_serial_clock_and_buffers_tb.sv
// sync_serial_clock_and_buffers_tb: apb driven checks of buffers, clock and bit order
// assumes ssc_top and ssc_partner, 20 MHz clock
`timescale 1ns/1ps
module sync_serial_clock_and_buffers_tb;
    import ssc_pkg::*;
    logic        clk, reset_n, psel, penable, pwrite, pready, pslverr, err, dir, msb_first;
    logic        divider_option_bit, slow_mode, fs_tick, sck_out, sck_oe_n, sdi, sdo, ext_sck;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd, seed, last_rx;
    logic [3:0]  pstrb, fs_cnt;
    logic [7:0]  ptx, prx, a, b;
    logic [2:0]  sel;
    int          nbits, n, k, per, bad_count, total_checks;
    wire         sck_pin = sck_oe_n ? ext_sck : sck_out;
    ssc_top ssc_top_inst (.clk(clk), .reset_n(reset_n), .paddr(paddr), .psel(psel),
        .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .pstrb(pstrb),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .divider_option_bit(divider_option_bit), .slow_mode(slow_mode), .fs_tick(fs_tick),
        .serial_clock_pin_in(sck_pin), .serial_clock_pin_out(sck_out),
        .serial_clock_pin_oe_n(sck_oe_n), .serial_data_in(sdi), .serial_data_out(sdo));
    ssc_partner ssc_partner_inst (.clk(clk), .sck(sck_pin), .sdo(sdo),
        .msb_first(msb_first), .tx_byte(ptx), .ext_sck(ext_sck), .sdi(sdi),
        .rx_byte(prx), .nbits(nbits));
    ////////////////////////////////////////////////////////////////////////////////
    // clock and low-frequency tick
    initial begin
        clk = 1'b0;
        forever #25 clk = ~clk;
    end
    always @(posedge clk) begin
        fs_cnt <= fs_cnt + 4'h1;
        fs_tick <= (fs_cnt == 4'hf);
    end
    function automatic logic [7:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed[7:0];
    endfunction
    // control word, transmit and receive mode
    function automatic logic [31:0] ctl(input logic st, input logic d, input logic [2:0] s);
        return {24'h0, st, 1'b0, 2'b10, d, s};
    endfunction
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        total_checks++;
        if (got !== exp) begin
            bad_count++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask
    task automatic apb(input logic wr, input logic [11:0] ad, input logic [31:0] d);
        @(posedge clk);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= ad;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task automatic wait_bits(input int m);
        k = 0;
        while (nbits < m && k < 3000) begin
            @(posedge clk);
            k++;
        end
        chk(k < 3000, 1'b1);
    endtask
    task automatic give_verdict();
        $display("checks %0d mismatches %0d", total_checks, bad_count);
        if (bad_count == 0 && total_checks > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge clk);
        bad_count++;
        give_verdict();
    end
    initial begin
        {psel, penable, pwrite, divider_option_bit, slow_mode, fs_tick} = 6'h00;
        {paddr, pwdata, fs_cnt, pstrb} = {12'h0, 32'h0, 4'h0, 4'hf};
        {seed, last_rx, bad_count, total_checks, reset_n} = {32'd90, 32'h0, 64'h0, 1'b0};
        repeat (5) @(posedge clk);
        reset_n <= 1'b1;
        apb(0, RX_BUF_ADDR, 0); chk(rd, 32'h0);
        apb(0, STAT_ADDR, 0); chk(rd, 32'h20);
        apb(0, 12'hffc, 0); chk(err, 1'b1);
        chk({sck_oe_n, sck_out}, 2'b01);
        for (int i = 0; i < 3; i++) begin
            sel = (i == 2) ? SEL_EXT : 3'(6 - i);
            dir = (i == 1);
            msb_first = ~dir;
            {a, b, ptx} = {rnd(), rnd(), rnd()};
            apb(1, CTRL_ADDR, ctl(0, dir, sel));
            apb(1, TX_BUF_ADDR, {24'h0, a});
            apb(1, TX_BUF_ADDR, {24'h0, b});
            apb(0, TX_BUF_ADDR, 0); chk(rd, last_rx);
            n = nbits;
            apb(1, CTRL_ADDR, ctl(1, dir, sel));
            if (sel == SEL_EXT) begin
                chk(sck_oe_n, 1'b1);
                ssc_partner_inst.ext_frame();
            end
            wait_bits(n + 8);
            repeat (8) @(posedge clk);
            chk(prx, a);
            apb(0, STAT_ADDR, 0); chk(rd[7], 1'b1);
            repeat (20) @(posedge clk);
            if (sel != SEL_EXT) chk({nbits == n + 8, sck_out}, 2'b11);
            apb(0, RX_BUF_ADDR, 0); chk(rd, ptx);
            last_rx = ptx;
            if (sel != SEL_EXT) begin
                per = 1 << (9 - sel);
                ptx = rnd();
                apb(1, TX_BUF_ADDR, {24'h0, b});
                k = 0;
                while (sck_out === 1'b1 && k < 60) begin
                    @(posedge clk) #1;
                    k++;
                end
                chk(k <= per + 2, 1'b1);
                k = 0;
                while (sck_out === 1'b0 && k < 60) begin
                    @(posedge clk) #1;
                    k++;
                end
                chk(k, per / 2);
                apb(1, CTRL_ADDR, ctl(0, dir, sel));
                wait_bits(n + 16);
                repeat (8) @(posedge clk);
                apb(0, STAT_ADDR, 0); chk(rd[7], 1'b0);
                chk(sck_out, 1'b1);
                chk(prx, b);
                apb(0, RX_BUF_ADDR, 0); chk(rd, ptx);
                last_rx = ptx;
            end
        end
        // inhibit from a waiting transfer, then fs/16 with the divider option
        apb(1, CTRL_ADDR, ctl(0, 1'b0, SEL_EXT) | 32'h40);
        apb(0, STAT_ADDR, 0); chk(rd, 32'h20);
        apb(0, RX_BUF_ADDR, 0); chk(rd, 32'h0);
        divider_option_bit <= 1'b1;
        apb(1, CTRL_ADDR, ctl(0, 1'b0, SEL_FS));
        apb(1, TX_BUF_ADDR, {24'h0, a});
        apb(1, CTRL_ADDR, ctl(1, 1'b0, SEL_FS));
        k = 0;
        while (sck_out === 1'b1 && k < 400) begin
            @(posedge clk) #1;
            k++;
        end
        k = 0;
        while (sck_out === 1'b0 && k < 400) begin
            @(posedge clk) #1;
            k++;
        end
        chk(k, 8 * 16);
        // inhibit in mid-byte stops the clock high and clears the flags
        apb(1, CTRL_ADDR, ctl(0, 1'b0, SEL_FS) | 32'h40);
        apb(0, STAT_ADDR, 0); chk(rd, 32'h20);
        chk(sck_out, 1'b1);
        give_verdict();
    end
endmodule // sync_serial_clock_and_buffers_tb
